// *** core/scc_channel.sv ***
// Purpose: scaling curve channel for a milliampere input
// Assumes: inSample is signed Q16.16, synchronous; point inputs ascend
// Notes: registers reached over AXI4-Lite
// Notes on behaviour
// - flag when input below minimum or above maximum
// - flag only when enabled; enable resets off
// - flag usable as logic and relay/LED output
// - input lost freezes last valid value
// - update cycle in 5 ms steps, 150 ms default
// - first-order averaging filter with time constant
// - output floating, floor, ceiling or nearest
// - default linear curve, points (0,0),(1,0)
// - extra points marked used, up to twenty
// - curve output readable for display
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
module scc_channel
   import scc_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYCLES
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic awvalid,
   output logic awready,
   input wire logic [11:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [11:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic [31:0] inSample,
   input wire logic inLost,
   output logic outOfRange,
   output logic [31:0] curveOut,
   output logic irq
);
   typedef enum logic [2:0] {IDLE, SCAN, CALC, DIV, WRITE} scc_state_e;

   typedef struct packed {
      logic awHeld;
      logic [11:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic oorEn;
      logic [1:0] rnd;
      logic [3:0] fShift;
      logic [10:0] updSteps;
      logic [31:0] inMin;
      logic [31:0] inMax;
      logic [NPTS-1:0] used;
      logic [NPTS-1:0][31:0] ptIn;
      logic [NPTS-1:0][31:0] ptOut;
      logic [IRQ_W-1:0] irqSt;
      logic [IRQ_W-1:0] irqMask;
      logic irqLine;
      logic [19:0] preCnt;
      logic [10:0] stepCnt;
      logic [31:0] filt;
      logic filtInit;
      logic lostD;
      logic oor;
      scc_state_e st;
      logic [4:0] idx;
      logic [4:0] lo;
      logic [4:0] hi;
      logic haveLo;
      logic haveHi;
      logic neg;
      logic divGo;
      logic [63:0] dNum;
      logic [31:0] dDen;
      logic [31:0] raw;
      logic [31:0] outVal;
      logic [31:0] sinceTick;
      logic seenTick;
   } scc_st_s;

   localparam logic [19:0] PRE_LAST = 20'(STEP_CYC - 1);

   scc_st_s q, n;
   logic tick;
   logic [10:0] stepsM1;
   logic divBusy;
   logic divDone;
   logic [31:0] divQuot;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            old[8*i +: 8] = d[8*i +: 8];
         end
      end
      return old;
   endfunction

   function automatic logic [31:0] roundVal(input logic [31:0] v, input logic [1:0] m);
      logic [31:0] fl;
      fl = v & ~FRAC_MASK;
      unique case (m)
         RND_FLOAT: return v;
         RND_FLOOR: return fl;
         RND_CEIL: return (v[FRAC_W-1:0] != '0) ? fl + ONE_Q : fl;
         RND_NEAR: return (v + HALF_Q) & ~FRAC_MASK;
      endcase
   endfunction

   // bit 32 flags an unmapped address
   function automatic logic [32:0] regRd(input scc_st_s s, input logic [11:0] a);
      logic [32:0] r;
      r = {1'b0, 32'h0000_0000};
      if (a[11:7] == PTIN_PAGE || a[11:7] == PTOUT_PAGE) begin
         if (a[6:2] > LAST_IDX) begin
            r[32] = 1'b1;
         end else if (a[11:7] == PTIN_PAGE) begin
            r[31:0] = s.ptIn[a[6:2]];
         end else begin
            r[31:0] = s.ptOut[a[6:2]];
         end
      end else begin
         unique case (a)
            OFF_CTRL: r[CTRL_SHF+3:0] = {s.fShift, 1'b0, s.rnd, s.oorEn};
            OFF_UPD: r[10:0] = s.updSteps;
            OFF_INMIN: r[31:0] = s.inMin;
            OFF_INMAX: r[31:0] = s.inMax;
            OFF_USED: r[NPTS-1:0] = s.used;
            OFF_STAT: r[2:0] = {s.st != IDLE, s.lostD, s.oor};
            OFF_INVAL: r[31:0] = s.filt;
            OFF_OUTVAL: r[31:0] = s.outVal;
            OFF_IRQST: r[IRQ_W-1:0] = s.irqSt;
            OFF_IRQMSK: r[IRQ_W-1:0] = s.irqMask;
            default: r[32] = 1'b1;
         endcase
      end
      return r;
   endfunction

   assign stepsM1 = (q.updSteps == '0) ? '0 : q.updSteps - 11'h001;
   assign tick = (q.preCnt == PRE_LAST) && (q.stepCnt >= stepsM1);

   always_comb begin
      logic [31:0] wv;
      logic [32:0] rd;
      logic [32:0] diff;
      logic [32:0] dx;
      logic [32:0] dOut;
      logic [65:0] prod;
      logic [31:0] den;
      wv = '0;
      rd = '0;
      diff = '0;
      dx = '0;
      dOut = '0;
      prod = '0;
      den = '0;
      n = q;
      n.divGo = 1'b0;
      // bus write: address and data taken in either order
      if (awvalid && !q.awHeld && !q.bValid) begin
         n.awHeld = 1'b1;
         n.awAddr = awaddr;
      end
      if (wvalid && !q.wHeld && !q.bValid) begin
         n.wHeld = 1'b1;
         n.wData = wdata;
         n.wStrb = wstrb;
      end
      if (q.bValid && bready) begin
         n.bValid = 1'b0;
      end
      if (q.awHeld && q.wHeld && !q.bValid) begin
         rd = regRd(q, q.awAddr);
         wv = mergeBytes(rd[31:0], q.wData, q.wStrb);
         n.awHeld = 1'b0;
         n.wHeld = 1'b0;
         n.bValid = 1'b1;
         n.bResp = rd[32] ? RESP_SLVERR : RESP_OKAY;
         if (q.awAddr[11:7] == PTIN_PAGE && !rd[32]) begin
            n.ptIn[q.awAddr[6:2]] = wv;
         end else if (q.awAddr[11:7] == PTOUT_PAGE && !rd[32]) begin
            n.ptOut[q.awAddr[6:2]] = wv;
         end else begin
            unique case (q.awAddr)
               OFF_CTRL: begin
                  n.oorEn = wv[CTRL_OOR];
                  n.rnd = wv[CTRL_RND +: 2];
                  n.fShift = wv[CTRL_SHF +: 4];
               end
               OFF_UPD: begin
                  n.updSteps = wv[10:0];
                  n.seenTick = 1'b0;
               end
               OFF_INMIN: n.inMin = wv;
               OFF_INMAX: n.inMax = wv;
               OFF_USED: n.used = wv[NPTS-1:0];
               OFF_IRQMSK: n.irqMask = wv[IRQ_W-1:0];
               default: ;
            endcase
         end
      end
      // bus read; reading the interrupt status clears it
      if (q.rValid && rready) begin
         n.rValid = 1'b0;
      end
      if (arvalid && !q.rValid) begin
         rd = regRd(q, araddr);
         n.rValid = 1'b1;
         n.rData = rd[31:0];
         n.rResp = rd[32] ? RESP_SLVERR : RESP_OKAY;
         if (araddr == OFF_IRQST) begin
            n.irqSt = '0;
         end
      end
      // update cycle divider
      if (q.preCnt == PRE_LAST) begin
         n.preCnt = '0;
         n.stepCnt = tick ? '0 : q.stepCnt + 11'h001;
      end else begin
         n.preCnt = q.preCnt + 20'h00001;
      end
      n.sinceTick = tick ? '0 : q.sinceTick + 32'h0000_0001;
      if (tick) begin
         n.seenTick = 1'b1;
      end
      n.lostD = inLost;
      n.oor = q.oorEn && (($signed(q.filt) < $signed(q.inMin)) || ($signed(q.filt) > $signed(q.inMax)));
      unique case (q.st)
         IDLE: begin
            if (tick && !inLost) begin
               diff = 33'($signed(inSample)) - 33'($signed(q.filt));
               diff = $signed(diff) >>> q.fShift;
               n.filt = q.filtInit ? q.filt + diff[31:0] : inSample;
               n.filtInit = 1'b1;
               n.idx = '0;
               n.haveLo = 1'b0;
               n.haveHi = 1'b0;
               n.st = SCAN;
            end
         end
         SCAN: begin
            if (q.used[q.idx] && !q.haveHi) begin
               if ($signed(q.ptIn[q.idx]) <= $signed(q.filt)) begin
                  n.lo = q.idx;
                  n.haveLo = 1'b1;
               end else begin
                  n.hi = q.idx;
                  n.haveHi = 1'b1;
               end
            end
            n.st = (q.idx == LAST_IDX) ? CALC : SCAN;
            n.idx = q.idx + 5'h01;
         end
         CALC: begin
            den = q.ptIn[q.hi] - q.ptIn[q.lo];
            n.st = WRITE;
            if (!q.haveLo && !q.haveHi) begin
               n.st = IDLE;
            end else if (!q.haveLo) begin
               n.raw = q.ptOut[q.hi];
            end else if (!q.haveHi || den == '0) begin
               n.raw = q.ptOut[q.lo];
            end else begin
               dx = 33'($signed(q.filt)) - 33'($signed(q.ptIn[q.lo]));
               dOut = 33'($signed(q.ptOut[q.hi])) - 33'($signed(q.ptOut[q.lo]));
               prod = $signed(dx) * $signed(dOut);
               n.neg = prod[65];
               prod = prod[65] ? -prod : prod;
               n.dNum = prod[63:0];
               n.dDen = den;
               n.divGo = 1'b1;
               n.st = DIV;
            end
         end
         DIV: begin
            if (divDone) begin
               n.raw = q.ptOut[q.lo] + (q.neg ? -divQuot : divQuot);
               n.st = WRITE;
            end
         end
         WRITE: begin
            n.outVal = roundVal(q.raw, q.rnd);
            n.st = IDLE;
         end
      endcase
      // events, set wins over the read clear
      if (q.st == WRITE) begin
         n.irqSt[IRQ_NEW] = 1'b1;
      end
      if (n.oor && !q.oor) begin
         n.irqSt[IRQ_OOR] = 1'b1;
      end
      if (inLost && !q.lostD) begin
         n.irqSt[IRQ_LOST] = 1'b1;
      end
      n.irqLine = |(n.irqSt & n.irqMask);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         q <= '0;
         q.updSteps <= UPD_STEPS_RST;
         q.used <= USED_RST;
         q.ptIn[1] <= PT2_IN_RST;
      end else begin
         q <= n;
      end
   end

   scc_divider u_div (
      .core_clk(core_clk),
      .rst(rst),
      .start(q.divGo),
      .num(q.dNum),
      .den(q.dDen),
      .busy(divBusy),
      .done(divDone),
      .quot(divQuot)
   );

   assign awready = !q.awHeld && !q.bValid;
   assign wready = !q.wHeld && !q.bValid;
   assign bvalid = q.bValid;
   assign bresp = q.bResp;
   assign arready = !q.rValid;
   assign rvalid = q.rValid;
   assign rdata = q.rData;
   assign rresp = q.rResp;
   assign outOfRange = q.oor;
   assign curveOut = q.outVal;
   assign irq = q.irqLine;

   a_oor_low: assert property (
      q.oorEn && ($signed(q.filt) < $signed(q.inMin)) |=> outOfRange)
      else $error("input below minimum without range flag");
   a_oor_off: assert property (!q.oorEn |=> !outOfRange)
      else $error("range flag raised while disabled");
   a_oor_event: assert property ($rose(outOfRange) |-> q.irqSt[IRQ_OOR])
      else $error("range flag rise not recorded");
   a_lost_hold: assert property (
      q.st == IDLE && tick && inLost |=> $stable(q.filt) && q.st == IDLE)
      else $error("lost input changed the value");
   a_tick_period: assert property (
      tick && q.seenTick |-> q.sinceTick == 32'(stepsM1 + 11'h001) * 32'(STEP_CYC) - 32'h0000_0001)
      else $error("update cycle length wrong");
   a_filter_first: assert property (
      q.st == IDLE && tick && !inLost && !q.filtInit |=> q.filt == $past(inSample))
      else $error("filter not seeded by first sample");
   a_round_int: assert property (
      q.st == WRITE && q.rnd != RND_FLOAT |=> curveOut[FRAC_W-1:0] == '0)
      else $error("integer mode left a fraction");
   a_round_ceil: assert property (
      q.st == WRITE && q.rnd == RND_CEIL |=> $signed(curveOut) >= $signed($past(q.raw)))
      else $error("ceiling rounded down");
   a_clamp_low: assert property (
      q.st == CALC && !q.haveLo && q.haveHi |=> q.raw == $past(q.ptOut[q.hi]) ##1 q.st == IDLE)
      else $error("value below first point not clamped");
   a_scan_skip: assert property (
      q.st == SCAN && !q.used[q.idx] |=> $stable(q.lo) && $stable(q.hi))
      else $error("unused point took part in the curve");
   a_read_out: assert property (
      arvalid && arready && araddr == OFF_OUTVAL |=> rvalid && rdata == $past(curveOut))
      else $error("curve output readback wrong");
   a_div_end: assert property (
      q.divGo |-> ##[65:67] q.st == WRITE)
      else $error("interpolation did not finish");
   a_div_free: assert property (q.divGo |-> !divBusy)
      else $error("divider started while busy");
endmodule

// *** shared/scc_pkg.sv ***
// Purpose: shared constants for the scaling curve channel
// Assumes: 125 MHz core clock, values are signed Q16.16
// Notes: byte offsets of the AXI4-Lite register map
package scc_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int STEP_TIME_NS = 5_000_000;
   localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STEP_MS = 5;
   localparam int DEF_UPDATE_MS = 150;
   localparam logic [10:0] UPD_STEPS_RST = 11'(DEF_UPDATE_MS / STEP_MS);
   localparam int NPTS = 20;
   localparam logic [4:0] LAST_IDX = 5'(NPTS - 1);
   localparam int FRAC_W = 16;
   localparam logic [31:0] ONE_Q = 32'h0001_0000;
   localparam logic [31:0] HALF_Q = 32'h0000_8000;
   localparam logic [31:0] FRAC_MASK = 32'h0000_ffff;
   localparam logic [31:0] PT2_IN_RST = ONE_Q;
   localparam logic [19:0] USED_RST = 20'h00003;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_UPD = 12'h004;
   localparam logic [11:0] OFF_INMIN = 12'h008;
   localparam logic [11:0] OFF_INMAX = 12'h00c;
   localparam logic [11:0] OFF_USED = 12'h010;
   localparam logic [11:0] OFF_STAT = 12'h014;
   localparam logic [11:0] OFF_INVAL = 12'h018;
   localparam logic [11:0] OFF_OUTVAL = 12'h01c;
   localparam logic [11:0] OFF_IRQST = 12'h020;
   localparam logic [11:0] OFF_IRQMSK = 12'h024;
   localparam logic [4:0] PTIN_PAGE = 5'h02;
   localparam logic [4:0] PTOUT_PAGE = 5'h03;
   localparam int CTRL_OOR = 0;
   localparam int CTRL_RND = 1;
   localparam int CTRL_SHF = 4;
   localparam int IRQ_W = 3;
   localparam int IRQ_NEW = 0;
   localparam int IRQ_OOR = 1;
   localparam int IRQ_LOST = 2;
   localparam logic [1:0] RND_FLOAT = 2'h0;
   localparam logic [1:0] RND_FLOOR = 2'h1;
   localparam logic [1:0] RND_CEIL = 2'h2;
   localparam logic [1:0] RND_NEAR = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [6:0] DIV_STEPS = 7'h40;
endpackage

// *** core/scc_divider.sv ***
// Purpose: serial unsigned 64 by 32 divider, one quotient bit per cycle
// Assumes: den is nonzero; start is ignored while busy
// Notes: quotient keeps the low 32 bits
`timescale 1ns/1ns
module scc_divider
   import scc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [63:0] num,
   input wire logic [31:0] den,
   output logic busy,
   output logic done,
   output logic [31:0] quot
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [6:0] cnt;
      logic [32:0] rem;
      logic [63:0] q;
      logic [31:0] d;
   } scc_div_s;

   scc_div_s q, n;

   always_comb begin
      logic [32:0] r;
      r = '0;
      n = q;
      n.done = 1'b0;
      if (!q.busy) begin
         if (start) begin
            n.busy = 1'b1;
            n.cnt = '0;
            n.rem = '0;
            n.q = num;
            n.d = den;
         end
      end else begin
         r = {q.rem[31:0], q.q[63]};
         n.q = {q.q[62:0], 1'b0};
         if (r >= {1'b0, q.d}) begin
            r = r - {1'b0, q.d};
            n.q[0] = 1'b1;
         end
         n.rem = r;
         n.cnt = q.cnt + 7'h01;
         if (q.cnt == DIV_STEPS - 7'h01) begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign busy = q.busy;
   assign done = q.done;
   assign quot = q.q[31:0];

   a_div_length: assert property (@(posedge core_clk) disable iff (rst)
      start && !busy |-> ##65 done)
      else $error("divider did not finish in 64 steps");
endmodule

// *** bench/scc_input_model.sv ***
// Purpose: model of the measured milliampere input feeding the channel
// Assumes: testbench calls set() to change the level or drop the signal
// Notes: a lost input shows no stable level, so the line flips every cycle
`timescale 1ns/1ns
module scc_input_model (
   input wire logic core_clk,
   output logic [31:0] inSample,
   output logic inLost
);
   logic [31:0] level_q = 32'h0;
   logic lost_q = 1'b0;
   task automatic set(input logic [31:0] v, input logic l);
      @(posedge core_clk);
      level_q <= v;
      lost_q <= l;
   endtask
   always @(posedge core_clk) begin
      inSample <= lost_q ? ~inSample : level_q;
      inLost <= lost_q;
   end
endmodule

// *** bench/testbench.sv ***
// Purpose: self-checking bench for the scaling curve channel
// Assumes: step shortened to 10 cycles, update cycle set to 20 steps
// Notes: registers reached through AXI4-Lite tasks
`timescale 1ns/1ns
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errors++; \
   $display("mismatch at %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
   import scc_pkg::*;
   localparam int STEP = 10;
   localparam int UPDV = 20;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, inLost, outOfRange, irq;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata, inSample, curveOut;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp;
   int errors = 0;
   int samplesChecked = 0;
   logic [1:0] md [4] = '{RND_FLOAT, RND_FLOOR, RND_CEIL, RND_NEAR};
   logic [31:0] smp [2] = '{32'h30000, 32'h28000};
   logic [31:0] exq [4][2] = '{'{32'h3c000, 32'h32000}, '{32'h30000, 32'h30000},
      '{32'h40000, 32'h40000}, '{32'h40000, 32'h30000}};
   logic [31:0] cyc;
   time t0;
   always #4 core_clk = ~core_clk;
   scc_input_model i_src (.core_clk, .inSample, .inLost);
   scc_channel #(.STEP_CYC(STEP)) i_dut (.core_clk, .rst, .awvalid, .awready, .awaddr, .wvalid, .wready,
      .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
      .rresp, .inSample, .inLost, .outOfRange, .curveOut, .irq);
   function automatic logic [11:0] pa(input logic [4:0] p, input int i);
      return {p, 5'(i), 2'b00};
   endfunction
   task automatic closeOut();
      $display("checks %0d mismatches %0d", samplesChecked, errors);
      if (errors == 0 && samplesChecked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic tmo();
      errors++;
      $display("mismatch at %0t timeout", $time);
      closeOut();
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge core_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         r = bresp;
         @(posedge core_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) begin
            bready <= 1'b0;
            break;
         end
      end
      if (n == 50) tmo();
      `CHK(r, er)
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ta, tr;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge core_clk);
         ta = arvalid && arready;
         tr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge core_clk);
         if (ta) arvalid <= 1'b0;
         if (tr) begin
            rready <= 1'b0;
            break;
         end
      end
      if (n == 50) tmo();
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      `CHK(d, e)
      `CHK(r, er)
   endtask
   // waits for a new-value interrupt, then clears it by reading the status
   task automatic wait_new();
      int n;
      logic [31:0] d;
      logic [1:0] r;
      repeat (2) @(posedge core_clk);
      for (n = 0; n < 1000; n++) begin
         @(negedge core_clk);
         if (irq === 1'b1) break;
      end
      if (n == 1000) tmo();
      rd(OFF_IRQST, d, r);
   endtask
   // second update is sure to use the new level
   task automatic upd(input logic [31:0] s);
      i_src.set(s, 1'b0);
      wait_new();
      wait_new();
      @(negedge core_clk);
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      rchk(OFF_CTRL, 32'h0, RESP_OKAY);
      rchk(OFF_UPD, 32'h1e, RESP_OKAY);
      rchk(OFF_USED, 32'h3, RESP_OKAY);
      rchk(pa(PTIN_PAGE, 0), 32'h0, RESP_OKAY);
      rchk(pa(PTIN_PAGE, 1), 32'h10000, RESP_OKAY);
      rchk(pa(PTOUT_PAGE, 1), 32'h0, RESP_OKAY);
      rchk(12'h0fc, 32'h0, RESP_SLVERR);
      wr(pa(PTIN_PAGE, 20), 32'h1, RESP_SLVERR);
      wr(OFF_IRQMSK, 32'h1, RESP_OKAY);
      wr(OFF_UPD, 32'(UPDV), RESP_OKAY);
      $display("test 1 done");
      upd(32'h8000);
      `CHK(curveOut, 32'h0)
      wr(pa(PTIN_PAGE, 1), 32'h40000, RESP_OKAY);
      wr(pa(PTOUT_PAGE, 1), 32'h50000, RESP_OKAY);
      for (int m = 0; m < 4; m++) begin
         wr(OFF_CTRL, 32'(md[m]) << CTRL_RND, RESP_OKAY);
         for (int k = 0; k < 2; k++) begin
            upd(smp[k]);
            `CHK(curveOut, exq[m][k])
         end
      end
      $display("test 2 done");
      wr(OFF_CTRL, 32'h0, RESP_OKAY);
      wr(pa(PTIN_PAGE, 2), 32'h60000, RESP_OKAY);
      wr(pa(PTOUT_PAGE, 2), 32'h90000, RESP_OKAY);
      wr(OFF_USED, 32'h7, RESP_OKAY);
      upd(32'h50000);
      `CHK(curveOut, 32'h70000)
      rchk(OFF_OUTVAL, 32'h70000, RESP_OKAY);
      upd(32'h70000);
      `CHK(curveOut, 32'h90000)
      $display("test 3 done");
      wait_new();
      t0 = $time;
      wait_new();
      cyc = 32'(($time - t0) / CLK_PERIOD_NS);
      `CHK(cyc, 32'(UPDV * STEP))
      $display("test 4 done");
      // three update cycles with the input lost, so several updates are skipped while the value holds
      wr(OFF_CTRL, 32'h1 << CTRL_SHF, RESP_OKAY);
      i_src.set(32'h10000, 1'b1);
      repeat (3 * UPDV * STEP) @(posedge core_clk);
      @(negedge core_clk);
      `CHK(curveOut, 32'h90000)
      `CHK(irq, 1'b0)
      rchk(OFF_STAT, 32'h2, RESP_OKAY);
      rchk(OFF_IRQST, 32'h4, RESP_OKAY);
      i_src.set(32'h30000, 1'b0);
      wait_new();
      rchk(OFF_INVAL, 32'h50000, RESP_OKAY);
      @(negedge core_clk);
      `CHK(curveOut, 32'h70000)
      $display("test 5 done");
      wr(OFF_INMIN, 32'h10000, RESP_OKAY);
      wr(OFF_INMAX, 32'h20000, RESP_OKAY);
      wr(OFF_CTRL, 32'h0, RESP_OKAY);
      upd(32'h30000);
      `CHK(outOfRange, 1'b0)
      wr(OFF_CTRL, 32'h1 << CTRL_OOR, RESP_OKAY);
      upd(32'h30000);
      `CHK(outOfRange, 1'b1)
      upd(32'h20000);
      `CHK(outOfRange, 1'b0)
      upd(32'h8000);
      `CHK(outOfRange, 1'b1)
      upd(32'hffff_0000);
      `CHK(curveOut, 32'h0)
      `CHK(outOfRange, 1'b1)
      $display("test 6 done");
      closeOut();
   end
endmodule
